// >>> core/spmdi_pkg.sv
// Operation
// - eight ID words at 1C40h..1C47h, always readable
// - words zero and two: sixteen die bits
// - word one: zero top two, fourteen bits
// - word three: revision nibble over twelve bits
// - word four: six die bits, rest zero
// - words five and six read all zero
// - word seven: checksum in bits 14..1
// - each port's six pads follow its mode
// - port0 mode 00 routes card lines
// - port0 mode 01 audio, pads 4-5 gpio
// - port0 mode 10 gpio 0..5
// - port1 modes 01 audio, 10 gpio 6..11
// - each pad has own pulldown inhibit bit
// - mode register updates the cycle after write, pad routing one cycle later
package spmdi_pkg;
	// register word addresses
	localparam logic [15:0] DIE_WORD0_ADDR = 16'h1c40;
	localparam logic [15:0] DIE_WORD1_ADDR = 16'h1c41;
	localparam logic [15:0] DIE_WORD2_ADDR = 16'h1c42;
	localparam logic [15:0] DIE_WORD3_ADDR = 16'h1c43;
	localparam logic [15:0] DIE_WORD4_ADDR = 16'h1c44;
	localparam logic [15:0] DIE_WORD5_ADDR = 16'h1c45;
	localparam logic [15:0] DIE_WORD6_ADDR = 16'h1c46;
	localparam logic [15:0] DIE_WORD7_ADDR = 16'h1c47;
	localparam logic [15:0] ROUTE_REG_ADDR = 16'h1c00;
	localparam logic [15:0] PD_INHIBIT_ADDR = 16'h1c17;
	// field positions
	localparam int SP0_MODE_LSB = 8;
	localparam int SP1_MODE_LSB = 10;
	localparam int REV_LSB = 12;
	localparam int CHECKSUM_LSB = 1;
	// sizes
	localparam int PADS_PER_PORT = 6;
	localparam int AUDIO_LINES = 4;
	localparam int PAD_COUNT = 12;
	// routing mode encodings
	typedef enum logic [1:0] {
		SPMDI_ROUTE_CARD = 2'h0,
		SPMDI_ROUTE_AUDIO = 2'h1,
		SPMDI_ROUTE_GPIO = 2'h2,
		SPMDI_ROUTE_NONE = 2'h3
	} spmdi_mode_t;
	// values after reset
	localparam spmdi_mode_t ROUTE_MODE_RST = SPMDI_ROUTE_CARD;
	localparam logic [11:0] PD_INHIBIT_RST = 12'h000;
	localparam logic [15:0] RDATA_RST = 16'h0000;
endpackage

// >>> core/spmdi_port_mux.sv
`timescale 1ns/10ps
`default_nettype none
// pad routing for one six-pad serial port; purely combinational
module spmdi_port_mux #(
	parameter bit HAS_CARD = 1'b1
) (
	// routing selection
	input wire spmdi_pkg::spmdi_mode_t mode,
	// peripheral drive side
	input wire logic [5:0] card_out,
	input wire logic [5:0] card_oe,
	input wire logic [3:0] audio_out,
	input wire logic [3:0] audio_oe,
	input wire logic [5:0] gpio_out,
	input wire logic [5:0] gpio_oe,
	// synchronised pad levels
	input wire logic [5:0] pad_in,
	// pad drive
	output logic [5:0] pad_out,
	output logic [5:0] pad_oe,
	// values returned to the peripherals
	output logic [5:0] card_in,
	output logic [3:0] audio_in,
	output logic [5:0] gpio_in
);
	// unselected peripherals see zero so stray edges never reach them
	always_comb
	begin
		pad_out = 6'h00;
		pad_oe = 6'h00;
		card_in = 6'h00;
		audio_in = 4'h0;
		gpio_in = 6'h00;
		case (mode)
			spmdi_pkg::SPMDI_ROUTE_CARD:
			begin
				if (HAS_CARD)
				begin
					pad_out = card_out;
					pad_oe = card_oe;
					card_in = pad_in;
				end
			end
			spmdi_pkg::SPMDI_ROUTE_AUDIO:
			begin
				pad_out = {gpio_out[5:4], audio_out};
				pad_oe = {gpio_oe[5:4], audio_oe};
				audio_in = pad_in[3:0];
				gpio_in = {pad_in[5:4], 4'h0};
			end
			spmdi_pkg::SPMDI_ROUTE_GPIO:
			begin
				pad_out = gpio_out;
				pad_oe = gpio_oe;
				gpio_in = pad_in;
			end
			// unsupported code: pads released
			default:
			begin
				pad_out = 6'h00;
			end
		endcase
	end
endmodule
`default_nettype wire

// >>> core/spmdi_top.sv
`timescale 1ns/10ps
`default_nettype none
// die identification words and serial-port pin routing
module spmdi_top #(
	// identification values; defaults are arbitrary
	parameter logic [15:0] DIE_ID0 = 16'h0000,
	parameter logic [13:0] DIE_ID1 = 14'h0000,
	parameter logic [15:0] DIE_ID2 = 16'h0000,
	parameter logic [11:0] DIE_ID3 = 12'h000,
	parameter logic [5:0] DIE_ID4 = 6'h00,
	parameter logic [3:0] SILICON_REVISION_CODE = 4'h0,
	parameter logic [13:0] CHECKSUM = 14'h0000
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// processor register port
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [15:0] cpu_wdata,
	output logic [15:0] cpu_rdata,
	output logic cpu_rvalid,
	// pads, port0 in [5:0], port1 in [11:6]
	input wire logic [11:0] pad_in,
	output logic [11:0] pad_out,
	output logic [11:0] pad_oe,
	output logic [11:0] pad_pulldown_en,
	// card0: clock, command, data0..3
	input wire logic [5:0] card0_out,
	input wire logic [5:0] card0_oe,
	output logic [5:0] card0_in,
	// audio ports: bit clock, frame sync, transmit, receive
	input wire logic [3:0] audio0_out,
	input wire logic [3:0] audio0_oe,
	output logic [3:0] audio0_in,
	input wire logic [3:0] audio1_out,
	input wire logic [3:0] audio1_oe,
	output logic [3:0] audio1_in,
	// general purpose bits 0..11
	input wire logic [11:0] gpio_out,
	input wire logic [11:0] gpio_oe,
	output logic [11:0] gpio_in
);
	typedef struct packed {
		spmdi_pkg::spmdi_mode_t port0_route_mode;
		spmdi_pkg::spmdi_mode_t port1_route_mode;
		logic [11:0] pulldown_inhibit_first;
		logic [15:0] rdata;
		logic rvalid;
		logic [11:0] sync1;
		logic [11:0] sync2;
		logic [11:0] pad_out;
		logic [11:0] pad_oe;
		logic [5:0] card0_in;
		logic [3:0] audio0_in;
		logic [3:0] audio1_in;
		logic [11:0] gpio_in;
	} spmdi_state_t;

	spmdi_state_t st_reg;
	spmdi_state_t st_next;
	logic [5:0] p0_out;
	logic [5:0] p0_oe;
	logic [5:0] p0_card_in;
	logic [3:0] p0_audio_in;
	logic [5:0] p0_gpio_in;
	logic [5:0] p1_out;
	logic [5:0] p1_oe;
	logic [3:0] p1_audio_in;
	logic [5:0] p1_gpio_in;
	logic [15:0] read_word;

	spmdi_port_mux #(
		.HAS_CARD(1'b1)
	) u_port0 (
		.mode(st_reg.port0_route_mode),
		.card_out(card0_out),
		.card_oe(card0_oe),
		.audio_out(audio0_out),
		.audio_oe(audio0_oe),
		.gpio_out(gpio_out[5:0]),
		.gpio_oe(gpio_oe[5:0]),
		.pad_in(st_reg.sync2[5:0]),
		.pad_out(p0_out),
		.pad_oe(p0_oe),
		.card_in(p0_card_in),
		.audio_in(p0_audio_in),
		.gpio_in(p0_gpio_in)
	);

	spmdi_port_mux #(
		.HAS_CARD(1'b0)
	) u_port1 (
		.mode(st_reg.port1_route_mode),
		.card_out(6'h00),
		.card_oe(6'h00),
		.audio_out(audio1_out),
		.audio_oe(audio1_oe),
		.gpio_out(gpio_out[11:6]),
		.gpio_oe(gpio_oe[11:6]),
		.pad_in(st_reg.sync2[11:6]),
		.pad_out(p1_out),
		.pad_oe(p1_oe),
		.card_in(),
		.audio_in(p1_audio_in),
		.gpio_in(p1_gpio_in)
	);

	// read decode; unmapped and reserved words read zero
	always_comb
	begin
		read_word = 16'h0000;
		case (cpu_addr)
			spmdi_pkg::DIE_WORD0_ADDR: read_word = DIE_ID0;
			spmdi_pkg::DIE_WORD1_ADDR: read_word = {2'h0, DIE_ID1};
			spmdi_pkg::DIE_WORD2_ADDR: read_word = DIE_ID2;
			spmdi_pkg::DIE_WORD3_ADDR: read_word = {SILICON_REVISION_CODE, DIE_ID3};
			spmdi_pkg::DIE_WORD4_ADDR: read_word = {10'h000, DIE_ID4};
			spmdi_pkg::DIE_WORD5_ADDR: read_word = 16'h0000;
			spmdi_pkg::DIE_WORD6_ADDR: read_word = 16'h0000;
			spmdi_pkg::DIE_WORD7_ADDR: read_word = {1'b0, CHECKSUM, 1'b0};
			spmdi_pkg::ROUTE_REG_ADDR: read_word = {4'h0, st_reg.port1_route_mode, st_reg.port0_route_mode, 8'h00};
			spmdi_pkg::PD_INHIBIT_ADDR: read_word = {4'h0, st_reg.pulldown_inhibit_first};
			default: read_word = 16'h0000;
		endcase
	end

	// next-state: register writes, read capture, pad sync and routing
	always_comb
	begin
		st_next = st_reg;
		st_next.rvalid = cpu_rd;
		if (cpu_rd)
		begin
			st_next.rdata = read_word;
		end
		// only routing and pulldown words take writes
		if (cpu_wr && cpu_addr == spmdi_pkg::ROUTE_REG_ADDR)
		begin
			st_next.port0_route_mode = spmdi_pkg::spmdi_mode_t'(cpu_wdata[spmdi_pkg::SP0_MODE_LSB +: 2]);
			st_next.port1_route_mode = spmdi_pkg::spmdi_mode_t'(cpu_wdata[spmdi_pkg::SP1_MODE_LSB +: 2]);
		end
		if (cpu_wr && cpu_addr == spmdi_pkg::PD_INHIBIT_ADDR)
		begin
			st_next.pulldown_inhibit_first = cpu_wdata[11:0];
		end
		// pads are asynchronous: two flops before any routing logic
		st_next.sync1 = pad_in;
		st_next.sync2 = st_reg.sync1;
		// routing is registered, one cycle behind the mode register
		st_next.pad_out = {p1_out, p0_out};
		st_next.pad_oe = {p1_oe, p0_oe};
		st_next.card0_in = p0_card_in;
		st_next.audio0_in = p0_audio_in;
		st_next.audio1_in = p1_audio_in;
		st_next.gpio_in = {p1_gpio_in, p0_gpio_in};
	end

	// state register with synchronous reset
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			st_reg <= '0;
			st_reg.port0_route_mode <= spmdi_pkg::ROUTE_MODE_RST;
			st_reg.port1_route_mode <= spmdi_pkg::ROUTE_MODE_RST;
			st_reg.pulldown_inhibit_first <= spmdi_pkg::PD_INHIBIT_RST;
			st_reg.rdata <= spmdi_pkg::RDATA_RST;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// outputs straight from state
	assign cpu_rdata = st_reg.rdata;
	assign cpu_rvalid = st_reg.rvalid;
	assign pad_out = st_reg.pad_out;
	assign pad_oe = st_reg.pad_oe;
	assign pad_pulldown_en = ~st_reg.pulldown_inhibit_first;
	assign card0_in = st_reg.card0_in;
	assign audio0_in = st_reg.audio0_in;
	assign audio1_in = st_reg.audio1_in;
	assign gpio_in = st_reg.gpio_in;

	// checks on the registered behaviour
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	id_range_read_a: assert property (cpu_rd && cpu_addr >= spmdi_pkg::DIE_WORD0_ADDR
		&& cpu_addr <= spmdi_pkg::DIE_WORD7_ADDR |=> cpu_rvalid)
		else $error("id read not answered");
	rvalid_pulse_a: assert property (!cpu_rd |=> !cpu_rvalid)
		else $error("read answer without a read");
	rdata_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata))
		else $error("read data changed without a read");
	word0_value_a: assert property (cpu_rd && cpu_addr == spmdi_pkg::DIE_WORD0_ADDR
		|=> cpu_rdata == DIE_ID0)
		else $error("word0 wrong");
	word2_value_a: assert property (cpu_rd && cpu_addr == spmdi_pkg::DIE_WORD2_ADDR
		|=> cpu_rdata == DIE_ID2)
		else $error("word2 wrong");
	word1_value_a: assert property (cpu_rd && cpu_addr == spmdi_pkg::DIE_WORD1_ADDR
		|=> cpu_rdata[15:14] == 2'h0 && cpu_rdata[13:0] == DIE_ID1)
		else $error("word1 wrong");
	word3_rev_a: assert property (cpu_rd && cpu_addr == spmdi_pkg::DIE_WORD3_ADDR
		|=> cpu_rdata[15:12] == SILICON_REVISION_CODE && cpu_rdata[11:0] == DIE_ID3)
		else $error("revision word wrong");
	word4_value_a: assert property (cpu_rd && cpu_addr == spmdi_pkg::DIE_WORD4_ADDR
		|=> cpu_rdata == {10'h000, DIE_ID4})
		else $error("word4 wrong");
	reserved_zero_a: assert property (cpu_rd && (cpu_addr == spmdi_pkg::DIE_WORD5_ADDR
		|| cpu_addr == spmdi_pkg::DIE_WORD6_ADDR) |=> cpu_rdata == 16'h0000)
		else $error("reserved word nonzero");
	checksum_word_a: assert property (cpu_rd && cpu_addr == spmdi_pkg::DIE_WORD7_ADDR
		|=> !cpu_rdata[15] && !cpu_rdata[0] && cpu_rdata[14:1] == CHECKSUM)
		else $error("checksum word wrong");
	id_write_a: assert property (cpu_wr && cpu_addr[15:3] == spmdi_pkg::DIE_WORD0_ADDR[15:3]
		|=> $stable(st_reg.port0_route_mode) && $stable(st_reg.port1_route_mode)
		&& $stable(st_reg.pulldown_inhibit_first))
		else $error("id write changed state");
	route_hold_a: assert property (!(cpu_wr && cpu_addr == spmdi_pkg::ROUTE_REG_ADDR)
		|=> $stable(st_reg.port0_route_mode) && $stable(st_reg.port1_route_mode))
		else $error("routing mode changed without a write");
	port0_idle_a: assert property (st_reg.port0_route_mode == spmdi_pkg::SPMDI_ROUTE_NONE
		|=> pad_oe[5:0] == 6'h00 && card0_in == 6'h00 && audio0_in == 4'h0)
		else $error("port0 driven in unsupported mode");
	port1_idle_a: assert property (st_reg.port1_route_mode == spmdi_pkg::SPMDI_ROUTE_CARD
		|=> pad_oe[11:6] == 6'h00)
		else $error("port1 driven in unsupported mode");
	card_route_a: assert property (st_reg.port0_route_mode == spmdi_pkg::SPMDI_ROUTE_CARD
		|=> pad_out[5:0] == $past(card0_out) && pad_oe[5:0] == $past(card0_oe))
		else $error("card routing wrong");
	card_quiet_a: assert property (st_reg.port0_route_mode != spmdi_pkg::SPMDI_ROUTE_CARD
		|=> card0_in == 6'h00)
		else $error("card input live outside card mode");
	gpio_quiet_a: assert property (st_reg.port0_route_mode == spmdi_pkg::SPMDI_ROUTE_CARD
		|=> gpio_in[5:0] == 6'h00)
		else $error("gpio input live in card mode");
	audio0_route_a: assert property (st_reg.port0_route_mode == spmdi_pkg::SPMDI_ROUTE_AUDIO
		|=> pad_oe[5:0] == {$past(gpio_oe[5:4]), $past(audio0_oe)})
		else $error("port0 audio routing wrong");
	route_write_a: assert property (cpu_wr && cpu_addr == spmdi_pkg::ROUTE_REG_ADDR && cpu_wdata[9:8] == 2'h2
		|-> ##2 pad_out[5:0] == $past(gpio_out[5:0]))
		else $error("gpio routing late or wrong");
	gpio0_return_a: assert property (st_reg.port0_route_mode == spmdi_pkg::SPMDI_ROUTE_GPIO
		|=> gpio_in[5:0] == $past(st_reg.sync2[5:0]))
		else $error("port0 gpio input wrong");
	port1_route_a: assert property (st_reg.port1_route_mode == spmdi_pkg::SPMDI_ROUTE_AUDIO
		|=> pad_out[11:6] == {$past(gpio_out[11:10]), $past(audio1_out)})
		else $error("port1 audio routing wrong");
	audio1_return_a: assert property (st_reg.port1_route_mode == spmdi_pkg::SPMDI_ROUTE_AUDIO
		|=> audio1_in == $past(st_reg.sync2[9:6]) && gpio_in[9:6] == 4'h0)
		else $error("port1 audio input wrong");
	pulldown_write_a: assert property (cpu_wr && cpu_addr == spmdi_pkg::PD_INHIBIT_ADDR
		|=> pad_pulldown_en == ~$past(cpu_wdata[11:0]))
		else $error("pulldown inhibit not applied");
	pulldown_hold_a: assert property (!(cpu_wr && cpu_addr == spmdi_pkg::PD_INHIBIT_ADDR)
		|=> $stable(pad_pulldown_en))
		else $error("pulldown changed without a write");
	route_update_a: assert property (cpu_wr && cpu_addr == spmdi_pkg::ROUTE_REG_ADDR
		|=> st_reg.port0_route_mode == spmdi_pkg::spmdi_mode_t'($past(cpu_wdata[9:8]))
		&& st_reg.port1_route_mode == spmdi_pkg::spmdi_mode_t'($past(cpu_wdata[11:10])))
		else $error("routing mode not taken");

	// main scenarios reached
	route_gpio_c: cover property (cpu_wr && cpu_addr == spmdi_pkg::ROUTE_REG_ADDR ##2 st_reg.port0_route_mode == spmdi_pkg::SPMDI_ROUTE_GPIO);
	rev_read_c: cover property (cpu_rd && cpu_addr == spmdi_pkg::DIE_WORD3_ADDR ##1 cpu_rvalid);
	port1_audio_c: cover property (st_reg.port1_route_mode == spmdi_pkg::SPMDI_ROUTE_AUDIO && audio1_oe[0]);
	port0_idle_c: cover property (st_reg.port0_route_mode == spmdi_pkg::SPMDI_ROUTE_NONE);
	pulldown_off_c: cover property (pad_pulldown_en[0] == 1'b0 && pad_oe[0] == 1'b0);
endmodule
`default_nettype wire

// >>> dv/serial_pin_mux_and_die_id_test.sv
`timescale 1ns/10ps
`default_nettype none
module serial_pin_mux_and_die_id_test;
	// identification values, arbitrary
	localparam logic [15:0] ID0 = 16'ha5c3;
	localparam logic [13:0] ID1 = 14'h2b7e;
	localparam logic [15:0] ID2 = 16'h5a3c;
	localparam logic [11:0] ID3 = 12'h9d1;
	localparam logic [5:0] ID4 = 6'h2d;
	localparam logic [3:0] REV = 4'h3;
	localparam logic [13:0] CKS = 14'h1e6b;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic cpu_rd = 1'b0, cpu_wr = 1'b0, cpu_rvalid;
	logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000, cpu_rdata;
	logic [11:0] pad_in, pad_out, pad_oe, pad_pulldown_en, gpio_in;
	logic [11:0] gpio_out = 12'h000, gpio_oe = 12'h000, ext_val = 12'h000, ext_en = 12'hfff;
	logic [5:0] card0_out = 6'h00, card0_oe = 6'h00, card0_in;
	logic [3:0] audio0_out = 4'h0, audio0_oe = 4'h0, audio1_out = 4'h0, audio1_oe = 4'h0, audio0_in, audio1_in;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h50db_40f7;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	always #25 mclk = ~mclk;
	spmdi_top #(.DIE_ID0(ID0), .DIE_ID1(ID1), .DIE_ID2(ID2), .DIE_ID3(ID3), .DIE_ID4(ID4),
		.SILICON_REVISION_CODE(REV), .CHECKSUM(CKS)) u_dut (.mclk(mclk), .resetn(resetn),
		.cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.cpu_rvalid(cpu_rvalid), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pulldown_en(pad_pulldown_en), .card0_out(card0_out), .card0_oe(card0_oe), .card0_in(card0_in),
		.audio0_out(audio0_out), .audio0_oe(audio0_oe), .audio0_in(audio0_in), .audio1_out(audio1_out),
		.audio1_oe(audio1_oe), .audio1_in(audio1_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in));
	spmdi_pad_world u_pads (.mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pulldown_en(pad_pulldown_en),
		.ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected identification word k
	function automatic logic [15:0] idw(input int k);
		case (k)
			0: return ID0;
			2: return ID2;
			1: return {2'h0, ID1};
			3: return {REV, ID3};
			4: return {10'h000, ID4};
			7: return {1'b0, CKS, 1'b0};
			default: return 16'h0000;
		endcase
	endfunction
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp50(input logic [49:0] got, input logic [49:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one register cycle per edge; back to back calls keep the strobe up
	task automatic bus(input logic rd, input logic wr, input logic [15:0] a, input logic [15:0] d,
		input logic [15:0] e);
		@(posedge mclk);
		cpu_rd <= rd;
		cpu_wr <= wr;
		cpu_addr <= a;
		cpu_wdata <= d;
		if (rd)
			exp_q.push_back(e);
	endtask
	// route both ports, drive random traffic and check every pad and return path
	task automatic check_route(input logic [1:0] m0, input logic [1:0] m1);
		logic [31:0] r, r2, r3, r4;
		logic [11:0] o, oe, lvl, g;
		r = xs();
		r2 = xs();
		r3 = xs();
		r4 = xs();
		// peripherals quiet and reset, so each boot routes once
		@(posedge mclk);
		cpu_rd <= 1'b0;
		cpu_wr <= 1'b0;
		{card0_out, card0_oe, audio0_out, audio0_oe, audio1_out, audio1_oe} <= 28'h000_0000;
		{gpio_out, gpio_oe} <= 24'h00_0000;
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(negedge mclk);
		cmp16({4'h0, pad_pulldown_en}, 16'h0fff);
		bus(1'b1, 1'b0, spmdi_pkg::ROUTE_REG_ADDR, 16'h0000, 16'h0000);
		bus(1'b0, 1'b1, spmdi_pkg::ROUTE_REG_ADDR, {r[15:12], m1, m0, r[7:0]}, 16'h0000);
		bus(1'b0, 1'b1, spmdi_pkg::PD_INHIBIT_ADDR, {4'h0, r3[27:16]}, 16'h0000);
		bus(1'b1, 1'b0, spmdi_pkg::ROUTE_REG_ADDR, 16'h0000, {4'h0, m1, m0, 8'h00});
		bus(1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000);
		{card0_out, card0_oe, audio0_out, audio0_oe, audio1_out, audio1_oe} <= r2[27:0];
		{gpio_out, gpio_oe} <= {r[31:16], r3[7:0]};
		ext_val <= r3[11:0] ^ r[27:16];
		// inhibited pads always get an outside driver, so no expected level floats
		ext_en <= r4[11:0] | r3[27:16];
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		o = 12'h000;
		oe = 12'h000;
		case (m0)
			2'h0: {o[5:0], oe[5:0]} = {card0_out, card0_oe};
			2'h1: {o[5:0], oe[5:0]} = {gpio_out[5:4], audio0_out, gpio_oe[5:4], audio0_oe};
			2'h2: {o[5:0], oe[5:0]} = {gpio_out[5:0], gpio_oe[5:0]};
			default: ;
		endcase
		if (m1 == 2'h1)
			{o[11:6], oe[11:6]} = {gpio_out[11:10], audio1_out, gpio_oe[11:10], audio1_oe};
		if (m1 == 2'h2)
			{o[11:6], oe[11:6]} = {gpio_out[11:6], gpio_oe[11:6]};
		lvl = (oe & o) | (~oe & ext_en & ext_val);
		g = 12'h000;
		if (m0 == 2'h2)
			g[5:0] = lvl[5:0];
		if (m0 == 2'h1)
			g[5:4] = lvl[5:4];
		if (m1 == 2'h2)
			g[11:6] = lvl[11:6];
		if (m1 == 2'h1)
			g[11:10] = lvl[11:10];
		cmp50({pad_out, pad_oe, card0_in, audio0_in, audio1_in, gpio_in}, {o, oe, (m0 == 2'h0) ? lvl[5:0] : 6'h00,
			(m0 == 2'h1) ? lvl[3:0] : 4'h0, (m1 == 2'h1) ? lvl[9:6] : 4'h0, g});
		cmp16({4'h0, pad_pulldown_en}, {4'h0, ~r3[27:16]});
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// read answers are matched oldest first
	always @(negedge mclk)
		if (cpu_rvalid === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				mismatches++;
				$display("CHECK FAILED t=%0t got=%h exp=none", $time, cpu_rdata);
			end
			else
				cmp16(cpu_rdata, exp_q.pop_front());
		end
	// hang guard, far above the roughly 135 cycles the run needs
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial
	begin
		logic [31:0] r;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		// back to back reads of all words
		for (int k = 0; k < 8; k++)
			bus(1'b1, 1'b0, spmdi_pkg::DIE_WORD0_ADDR + 16'(k), 16'h0000, idw(k));
		for (int k = 0; k < 8; k++)
		begin
			r = xs();
			bus(1'b0, 1'b1, spmdi_pkg::DIE_WORD0_ADDR + 16'(k), r[15:0], 16'h0000);
		end
		for (int k = 0; k < 8; k++)
			bus(1'b1, 1'b0, spmdi_pkg::DIE_WORD0_ADDR + 16'(k), 16'h0000, idw(k));
		bus(1'b1, 1'b0, 16'h1c48, 16'h0000, 16'h0000);
		// port1 only ever gets 01 or 10
		for (int i = 0; i < 8; i++)
			check_route(2'(i % 4), 2'(1 + i % 2));
		bus(1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000);
		repeat (3) @(posedge mclk);
		cmp16(16'(exp_q.size()), 16'h0000);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// >>> dv/spmdi_pad_world.sv
`timescale 1ns/10ps
`default_nettype none
// board side of the twelve serial pads
module spmdi_pad_world (
	// clock for the wandering level
	input wire logic mclk,
	// chip pad drive
	input wire logic [11:0] pad_out,
	input wire logic [11:0] pad_oe,
	input wire logic [11:0] pad_pulldown_en,
	// external drivers
	input wire logic [11:0] ext_val,
	input wire logic [11:0] ext_en,
	// level seen by the chip
	output logic [11:0] pad_in
);
	logic [11:0] float_reg = 12'h5a5;
	// an undriven pad without pulldown wanders, so a stale level never passes
	always @(posedge mclk)
		float_reg <= ~float_reg;
	always_comb
		pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & ~pad_pulldown_en & float_reg);
endmodule
`default_nettype wire
